// file: ftsp_pkg.sv
/*
 * Constants, encodings and TAP codes for the flow-through synchronous SRAM
 * port. Assumes nothing of its surroundings; every design file except the storage interface imports it.
 */
package ftsp_pkg;

    // ************************************************************
    // Organisation
    // ************************************************************
    localparam int ADDR_W_DEF = 21;
    localparam int DATA_W_DEF = 36;
    localparam int LANE_W = 9;
    localparam int BURST_W = 2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int BUS_MHZ_MAX = 133;
    localparam int CLK_MHZ = 40;
    localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic ORDER_INTERLEAVED = 1'b1;
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;

    // ************************************************************
    // Bus cycle kinds
    // ************************************************************
    typedef enum logic [2:0] {
        OP_IDLE  = 3'b001,
        OP_READ  = 3'b010,
        OP_WRITE = 3'b100
    } ftsp_op_e;

    // ************************************************************
    // Test access port
    // ************************************************************
    typedef enum logic [15:0] {
        TS_RESET   = 16'h0001,
        TS_IDLE    = 16'h0002,
        TS_SEL_DR  = 16'h0004,
        TS_CAP_DR  = 16'h0008,
        TS_SH_DR   = 16'h0010,
        TS_EX1_DR  = 16'h0020,
        TS_PAU_DR  = 16'h0040,
        TS_EX2_DR  = 16'h0080,
        TS_UPD_DR  = 16'h0100,
        TS_SEL_IR  = 16'h0200,
        TS_CAP_IR  = 16'h0400,
        TS_SH_IR   = 16'h0800,
        TS_EX1_IR  = 16'h1000,
        TS_PAU_IR  = 16'h2000,
        TS_EX2_IR  = 16'h4000,
        TS_UPD_IR  = 16'h8000
    } ftsp_tap_e;

    localparam int IR_W = 3;
    localparam int DR_W = 32;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
    // Arbitrary neutral identification value; bit 0 must stay set.
    localparam logic [DR_W-1:0] IDCODE_DEF = 32'h0A5A_5001;

endpackage

// file: ftsp_mem_if.sv
/*
 * Storage-side carrier between the port controller and the cell array.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ftsp_mem_if #(
    parameter int AW = 21,
    parameter int DW = 36,
    parameter int LANES = 4
);
    logic wr_en;
    logic [LANES-1:0] lane_we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output wr_en, output lane_we, output addr, output wdata,
                  input rdata);
    modport store (input wr_en, input lane_we, input addr, input wdata,
                   output rdata);
endinterface

// file: ftsp_array.sv
/*
 * Cell array with per-lane write and a combinational read port.
 * Assumes the controller holds the address stable for the whole cycle.
 */
`timescale 1ns/1ps
module ftsp_array
    import ftsp_pkg::*;
#(
    parameter int AW = ADDR_W_DEF,
    parameter int DW = DATA_W_DEF
) (
    // Clock
    input wire logic clk,
    // Storage port
    ftsp_mem_if.store mem
);
    localparam int LANES = DW / LANE_W;

    logic [DW-1:0] cells [0:(1<<AW)-1];

    // ************************************************************
    // Write and read
    // ************************************************************
    // lane-masked write
    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (mem.lane_we[l]) begin
                    cells[mem.addr][l*LANE_W +: LANE_W] <=
                        mem.wdata[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign mem.rdata = cells[mem.addr];

endmodule // ftsp_array

// file: ftsp_port.sv
/*
 * Flow-through synchronous burst SRAM port: input registers, clock
 * qualify, chip selects, burst sequencing, output buffer control, sleep
 * and a small test access port. Assumes all inputs, including the test
 * clock, are synchronous to clk, which must run faster than the test clock.
 */
`timescale 1ns/1ps

module ftsp_port
    import ftsp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter logic [DR_W-1:0] IDCODE = IDCODE_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Address and control
    input wire logic [ADDR_W-1:0] addr,
    input wire logic write_en_n,
    input wire logic burst_advance,
    input wire logic clk_qualify_n,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    input wire logic [DATA_W/LANE_W-1:0] byte_lane_write_n,
    // Data bus
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    input wire logic out_enable_n,
    // Mode and power
    input wire logic burst_order_strap,
    input wire logic sleep_request,
    output logic low_power,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n
);
    localparam int LANES = DATA_W / LANE_W;

    typedef struct packed {
        ftsp_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_n;
        logic [BURST_W-1:0] cnt;
        logic interleave;
        logic tck;
        ftsp_tap_e tap;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sr;
        logic [DR_W-1:0] dr_sr;
        logic tdo;
        logic tdo_en;
    } ftsp_state_s;

    ftsp_state_s q;
    ftsp_state_s d;
    logic sel;
    logic tck_rise;
    logic tck_fall;
    logic [ADDR_W-1:0] beat_addr;

    ftsp_mem_if #(.AW(ADDR_W), .DW(DATA_W), .LANES(LANES)) mem ();

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base,
        input logic [BURST_W-1:0] cnt,
        input logic ilv
    );
        logic [BURST_W-1:0] low;
        low = ilv ? (base[BURST_W-1:0] ^ cnt)
                  : BURST_W'(base[BURST_W-1:0] + cnt);
        return {base[ADDR_W-1:BURST_W], low};
    endfunction

    function automatic ftsp_tap_e tap_next(input ftsp_tap_e s,
                                           input logic m);
        case (s)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR: tap_next = m ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_next = m ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: tap_next = m ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: tap_next = m ? TS_UPD_DR : TS_SH_DR;
            TS_UPD_DR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_next = m ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR: tap_next = m ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_next = m ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: tap_next = m ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: tap_next = m ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            default: tap_next = TS_RESET;
        endcase
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    // all three selects
    assign sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    assign tck_rise = tck && !q.tck;
    assign tck_fall = !tck && q.tck;
    assign beat_addr = burst_addr(q.addr, q.cnt, q.interleave);

    always_comb begin
        d = q;
        mem.wr_en = 1'b0;
        mem.lane_we = '0;
        mem.addr = beat_addr;
        mem.wdata = dq_in;
        d.tck = tck;
        if (!clk_qualify_n) begin
            // write data taken one edge after its address
            if (q.op == OP_WRITE && !rst) begin
                mem.wr_en = 1'b1;
                mem.lane_we = ~q.lane_n;
            end
            if (burst_advance && q.op != OP_IDLE && !sleep_request) begin
                d.cnt = BURST_W'(q.cnt + 1'b1);
                d.lane_n = byte_lane_write_n;
            end else if (sel && !sleep_request) begin
                d.op = write_en_n ? OP_READ : OP_WRITE;
                d.addr = addr;
                d.lane_n = byte_lane_write_n;
                d.cnt = BURST_CNT_RST;
            // deselect without a burst advance, or sleep, idles the core
            end else begin
                d.op = OP_IDLE;
                d.cnt = BURST_CNT_RST;
            end
        end
        if (tck_rise) begin
            d.tap = tap_next(q.tap, tms);
            case (q.tap)
                TS_RESET: d.ir = IR_IDCODE;
                TS_CAP_IR: d.ir_sr = IR_CAPTURE;
                TS_SH_IR: d.ir_sr = {tdi, q.ir_sr[IR_W-1:1]};
                TS_UPD_IR: d.ir = q.ir_sr;
                TS_CAP_DR: d.dr_sr = (q.ir == IR_IDCODE) ? IDCODE : '0;
                TS_SH_DR: begin
                    if (q.ir == IR_IDCODE) begin
                        d.dr_sr = {tdi, q.dr_sr[DR_W-1:1]};
                    end else begin
                        d.dr_sr = {{(DR_W-1){1'b0}}, tdi};
                    end
                end
                default: d.ir = q.ir;
            endcase
        end
        // Test data out changes on the falling test clock edge.
        if (tck_fall) begin
            d.tdo_en = (q.tap == TS_SH_DR) || (q.tap == TS_SH_IR);
            d.tdo = (q.tap == TS_SH_IR) ? q.ir_sr[0] : q.dr_sr[0];
        end
        if (rst) begin
            d = '0;
            d.op = OP_IDLE;
            d.tap = TS_RESET;
            d.ir = IR_IDCODE;
            d.tck = tck;
            // strap caught while reset is held
            d.interleave = burst_order_strap;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // ************************************************************
    // Storage and outputs
    // ************************************************************
    // width follows parameters
    ftsp_array #(.AW(ADDR_W), .DW(DATA_W)) u_array (
        .clk(clk),
        .mem(mem)
    );

    assign dq_out = mem.rdata;

    // Drivers open only for a registered read; no clock on the enable
    // path, so the controller can park the bus at any moment.
    // self-timed turnaround
    assign dq_oe_n = !(q.op == OP_READ && !out_enable_n);

    assign low_power = sleep_request || (q.op == OP_IDLE);

    assign tdo = q.tdo;
    assign tdo_oe_n = !q.tdo_en;

    // zero wait at the top rate
    // No path waits on more than one edge, so any clock up to the
    // supported bus rate meets the same cycle timing.

endmodule // ftsp_port

// file: ftsp_port_sva.sv
/* Pin-level assertions for the flow-through port.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module ftsp_port_chk
    import ftsp_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic write_en_n,
    input wire logic burst_advance,
    input wire logic clk_qualify_n,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    input wire logic out_enable_n,
    input wire logic sleep_request,
    // Outputs
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic low_power,
    input wire logic tdo_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic go, sel, rd, wr;
    // ****************************************
    // New cycles
    // ****************************************
    assign go = !clk_qualify_n && !burst_advance && !sleep_request;
    assign sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    assign rd = go && sel && write_en_n;
    assign wr = go && sel && !write_en_n;
    sequence s_turn;
        wr ##1 (rd && dq_oe_n);
    endsequence
    property p_oe_async; !dq_oe_n |-> !out_enable_n; endproperty
    property p_wr_tri; wr |=> dq_oe_n; endproperty
    property p_rd_drive; rd |=> dq_oe_n == out_enable_n; endproperty
    property p_turn; s_turn |=> dq_oe_n == out_enable_n; endproperty
    property p_desel; go && !sel |=> dq_oe_n && low_power; endproperty
    property p_sleep;
        sleep_request && !clk_qualify_n |=> dq_oe_n && low_power;
    endproperty
    property p_rst_idle;
        $fell(rst) |-> dq_oe_n && low_power && tdo_oe_n;
    endproperty
    property p_stall;
        $past(clk_qualify_n) && !$past(rst) && $stable(out_enable_n)
            |-> $stable(dq_out) && $stable(dq_oe_n);
    endproperty
    a_oe_async: assert property (p_oe_async)
        else $error("data driven without output enable");
    a_wr_tri: assert property (p_wr_tri)
        else $error("driver on in write data phase");
    a_rd_drive: assert property (p_rd_drive)
        else $error("read word not driven");
    a_turn: assert property (p_turn)
        else $error("read after write not driven");
    a_desel: assert property (p_desel)
        else $error("deselected cycle not idle");
    a_sleep: assert property (p_sleep)
        else $error("sleep without low power");
    a_rst_idle: assert property (p_rst_idle)
        else $error("not idle after reset");
    a_stall: assert property (p_stall)
        else $error("outputs moved on an ignored edge");
endmodule // ftsp_port_chk

bind ftsp_port ftsp_port_chk #(.DATA_W(DATA_W)) i_ftsp_port_chk (
    .clk, .rst, .write_en_n, .burst_advance, .clk_qualify_n,
    .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .out_enable_n,
    .sleep_request, .dq_out, .dq_oe_n, .low_power, .tdo_oe_n);

// file: ftsp_ctrl_model.sv
/* Memory controller model driving the bus side of the port.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
module ftsp_ctrl_model
    import ftsp_pkg::*;
#(
    parameter int AW = 6,
    parameter int DW = 36
) (
    // Clock
    input wire logic clk,
    // Bus towards the port
    output logic [AW-1:0] addr,
    output logic write_en_n,
    output logic burst_advance,
    output logic clk_qualify_n,
    output logic chip_sel_a_n,
    output logic chip_sel_b,
    output logic chip_sel_c_n,
    output logic [DW/LANE_W-1:0] byte_lane_write_n,
    output logic [DW-1:0] dq_in
);
    logic [DW-1:0] pend = '0;
    logic pend_v = 1'b0;
    initial begin
        {addr, burst_advance, chip_sel_b, dq_in} = '0;
        {write_en_n, clk_qualify_n, chip_sel_a_n, chip_sel_c_n} = 4'hF;
        byte_lane_write_n = '1;
    end
    // ****************************************
    // Bus cycles
    // ****************************************
    // lanes and selects with the address, data one edge late
    task automatic beat(input logic wr, input logic adv,
            input logic [2:0] drop, input logic [AW-1:0] a,
            input logic [DW/LANE_W-1:0] ln, input logic [DW-1:0] d);
        @(negedge clk);
        clk_qualify_n = 1'b0;
        {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = drop ^ 3'h2;
        write_en_n = !wr;
        burst_advance = adv;
        addr = a;
        byte_lane_write_n = wr ? ln : '1;
        // An idle data bus toggles so stale data never looks valid.
        dq_in = pend_v ? pend : ~dq_in;
        pend_v = wr;
        pend = d;
        @(posedge clk);
        #1;
    endtask
    task automatic stall();
        @(negedge clk);
        clk_qualify_n = 1'b1;
        // A new address on the ignored edge shows whether it was taken.
        addr = ~addr;
        @(posedge clk);
        #1;
    endtask
endmodule // ftsp_ctrl_model

// file: test_ftsp_port.sv
/* Self-checking bench for the flow-through port.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
module test_ftsp_port
    import ftsp_pkg::*;
();
    localparam int AW = 6;
    localparam int DW = 36;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic out_enable_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_order_strap = 1'b1;
    logic tck = 1'b0;
    logic tms = 1'b1;
    logic tdo;
    logic [AW-1:0] addr;
    logic write_en_n, burst_advance, clk_qualify_n, dq_oe_n;
    logic chip_sel_a_n, chip_sel_b, chip_sel_c_n, low_power, tdo_oe_n;
    logic [DW/LANE_W-1:0] byte_lane_write_n;
    logic [DW-1:0] dq_in, dq_out;
    int err_count = 0;
    int compares = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    ftsp_ctrl_model #(.AW(AW), .DW(DW)) i_ftsp_ctrl_model (
        .clk, .addr, .write_en_n, .burst_advance, .clk_qualify_n,
        .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .byte_lane_write_n,
        .dq_in);
    ftsp_port #(.ADDR_W(AW), .DATA_W(DW)) i_ftsp_port (
        .clk, .rst, .addr, .write_en_n, .burst_advance, .clk_qualify_n,
        .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .byte_lane_write_n,
        .dq_in, .dq_out, .dq_oe_n, .out_enable_n, .burst_order_strap,
        .sleep_request, .low_power, .tck, .tms, .tdi(1'b0),
        .tdo, .tdo_oe_n);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [DW-1:0] pat(input logic [AW-1:0] a);
        return {a, ~a, 24'hA5C3E1};
    endfunction
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic reset(input logic strap);
        @(negedge clk);
        rst = 1'b1;
        burst_order_strap = strap;
        repeat (5) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [3:0] ln,
            input logic [DW-1:0] d);
        i_ftsp_ctrl_model.beat(1'b1, 1'b0, 3'h0, a, ln, d);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic adv);
        i_ftsp_ctrl_model.beat(1'b0, adv, 3'h0, a, 4'hF, '0);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_b2b();
        wr(6'h01, 4'h0, pat(6'h01));
        chk(dq_oe_n, 1'b1);
        wr(6'h02, 4'h0, pat(6'h02));
        rd(6'h01, 1'b0);
        chk(dq_out, pat(6'h01));
        wr(6'h01, 4'hA, ~pat(6'h01));
        chk(dq_oe_n, 1'b1);
        rd(6'h01, 1'b0);
        chk(dq_out, pat(6'h01) ^ 36'h007FC01FF);
        chk(dq_oe_n, 1'b0);
        rd(6'h02, 1'b0);
        chk(dq_out, pat(6'h02));
    endtask
    task automatic t_oe();
        i_ftsp_ctrl_model.stall();
        chk(dq_out, pat(6'h02));
        @(negedge clk);
        out_enable_n = 1'b1;
        #1;
        chk(dq_oe_n, 1'b1);
        out_enable_n = 1'b0;
        #1;
        chk(dq_oe_n, 1'b0);
    endtask
    task automatic t_sel();
        for (int i = 0; i < 3; i++) begin
            i_ftsp_ctrl_model.beat(1'b1, 1'b0, 3'(1 << i), 6'h02, 4'h0, '0);
            chk(low_power, 1'b1);
        end
        @(negedge clk);
        sleep_request = 1'b1;
        rd(6'h02, 1'b0);
        chk(dq_oe_n, 1'b1);
        @(negedge clk);
        sleep_request = 1'b0;
        rd(6'h02, 1'b0);
        chk(dq_out, pat(6'h02));
    endtask
    task automatic t_burst();
        logic [AW-1:0] b;
        for (int m = 0; m < 2; m++) begin
            reset(1'(1 - m));
            for (int k = 0; k < 4; k++)
                wr(6'(4 + k), 4'h0, pat(6'(4 + k)));
            for (int k = 0; k < 4; k++) begin
                b = (m == 0) ? 6'(5 ^ k) : 6'(4 + ((1 + k) % 4));
                rd(6'h05, k != 0);
                chk(dq_out, pat(b));
            end
        end
    endtask
    // Each test clock level lasts two clk periods, as the port requires.
    task automatic tap_step(input logic m, output logic o);
        @(negedge clk);
        tms = m;
        tck = 1'b1;
        repeat (2) @(negedge clk);
        tck = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        o = tdo;
    endtask
    task automatic t_tap();
        logic [DR_W-1:0] id;
        logic o;
        id = '0;
        tap_step(1'b0, o);
        tap_step(1'b1, o);
        tap_step(1'b0, o);
        for (int k = 0; k < DR_W; k++) begin
            tap_step(1'b0, o);
            id[k] = o;
        end
        chk(tdo_oe_n, 1'b0);
        chk(id, IDCODE_DEF);
    endtask
    initial begin
        reset(1'b1);
        t_b2b();
        t_oe();
        t_sel();
        t_burst();
        t_tap();
        summarize();
    end
    // The run needs about 190 cycles; five times that means a hang.
    initial begin
        #25000;
        err_count++;
        summarize();
    end
endmodule // test_ftsp_port
